// ### core/amc_pkg.sv
/*
  Constants and types for the converter mode configuration block:
  register indices, field positions, reset values, delay table.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package amc_pkg;

  ////////////////////////////////////////////////////////////////////
  // Bus and register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 6;

  localparam logic [IDX_W-1:0] CONVERSION_MODE_CONTROL_IDX  = 6'h03;
  localparam logic [IDX_W-1:0] FILTER_AND_BIAS_CONTROL_IDX  = 6'h04;
  localparam logic [IDX_W-1:0] GAIN_AND_RATE_CONTROL_IDX  = 6'h05;
  localparam logic [IDX_W-1:0] STATUS_IDX = 6'h3f;

  localparam logic [7:0] CONVERSION_MODE_CONTROL_RST = 8'h00;
  localparam logic [7:0] FILTER_AND_BIAS_CONTROL_RST = 8'h80;
  localparam logic [7:0] GAIN_AND_RATE_CONTROL_RST = 8'h04;

  ////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int REFINV_BIT = 7;
  localparam int RUN_BIT    = 6;
  localparam int CHOP_BIT   = 4;
  localparam int ROT_BIT    = 5;
  localparam int DELAY_LSB  = 0;
  localparam int FILT_LSB   = 5;
  localparam int ROUTE_BIT  = 4;
  localparam int PULL_BIT   = 3;
  localparam int MAG_LSB    = 0;
  localparam int BYP_BIT    = 7;
  localparam int GAIN_LSB   = 4;
  localparam int RATE_LSB   = 0;

  localparam int ST_BUSY    = 0;
  localparam int ST_DELAY   = 1;
  localparam int ST_CLAMP   = 2;

  ////////////////////////////////////////////////////////////////////
  // Codes
  localparam logic [2:0] FILT_FIR  = 3'h4;
  localparam logic [3:0] RATE_FIR3 = 4'h2;
  localparam logic [3:0] RATE_20   = 4'h4;
  localparam logic [3:0] DLY_LAST  = 4'hb;

  ////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_NS = 10;
  localparam int          DLY_W  = 20;
  localparam int unsigned DLY_NS [0:11] = '{0, 8700, 17000, 35000,
    69000, 139000, 278000, 555000, 1100000, 2200000, 4400000, 8800000};

  typedef struct packed {
    logic       reference_polarity_invert;
    logic       single_or_continuous_select;
    logic       input_chop_en;
    logic       current_rotate_en;
    logic [3:0] delay_code;
    logic [2:0] filter_sel;
    logic       bias_converter_route;
    logic       bias_pull_direction;
    logic [2:0] bias_strength_code;
    logic       pga_bypass;
    logic [2:0] gain_code;
    logic [3:0] output_rate_code;
  } amc_cfg_t;

  // Rounds up so the delay is never shorter than listed
  function automatic logic [DLY_W-1:0] amc_dly_ticks(
    input logic [3:0] code, input int unsigned tick_ns);
    int unsigned ns;
    ns = (code <= DLY_LAST) ? DLY_NS[code] : 0;
    return DLY_W'((ns + tick_ns - 1) / tick_ns);
  endfunction

endpackage

// ### core/amc_delay_timer.sv
/*
  Down-counter for the conversion start delay, counting ticks of
  the conversion clock enable. Assumes load and tick are on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module amc_delay_timer #(
  parameter int W = 17
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         tick_i,
  input  wire logic         load_i,
  input  wire logic         abort_i,
  input  wire logic [W-1:0] ticks_i,
  // Status
  output logic              done_o,
  output logic              busy_o
);

  logic [W-1:0] cnt_q;
  logic         run_q;
  logic         done_q;
  wire          at_zero = (cnt_q == '0);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= run_q & at_zero & ~abort_i;
      if (abort_i) begin
        run_q <= 1'b0;
      end else if (load_i) begin
        cnt_q <= ticks_i;
        run_q <= 1'b1;
      end else if (run_q && at_zero) begin
        run_q <= 1'b0;
      end else if (run_q && tick_i) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign done_o = done_q;
  assign busy_o = run_q;

endmodule
`default_nettype wire

// ### core/amc_mode_regs.sv
/*
  Converter mode configuration registers behind an APB slave, with
  the conversion start sequencer that applies run mode and delay.
  Assumes an APB master on clk_sys_i and a converter core that
  pulses conv_done_i at the end of each conversion.
*/
//
// Function
// - Bit 7 inverts reference selector polarity
// - Bit 6 picks continuous or single conversion
// - Bits 5:4 enable current rotation and chop
// - Bits 3:0 set delay before conversion
// - Second register bits 7:5 pick filter
// - Bit 4 routes bias to main/auxiliary
// - Bit 3 sets bias pull direction
// - Bits 2:0 set bias strength
// - Third register bit 7 bypasses amplifier
// - Bits 6:4 select amplifier gain
// - Bits 3:0 select output data rate
// - FIR filter allows only rate codes 0-2 and 4 (20 SPS)
// - First register at 03h, reset 00h
// - Second register at 04h, reset 80h
// - Third register at 05h, reset 04h
`timescale 1ns/1ns
`default_nettype none
module amc_mode_regs #(
  parameter int CONV_DIV = 10
) (
  // Clock and reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         rst_i,
  // APB slave
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [amc_pkg::ADDR_W-1:0]   paddr_i,
  input  wire logic [amc_pkg::DATA_W-1:0]   pwdata_i,
  input  wire logic [3:0]                   pstrb_i,
  output logic                              pready_o,
  output logic [amc_pkg::DATA_W-1:0]        prdata_o,
  output logic                              pslverr_o,
  // Converter core
  input  wire logic                         conv_start_i,
  input  wire logic                         conv_stop_i,
  input  wire logic                         conv_done_i,
  output logic                              conv_go_o,
  output logic                              conv_busy_o,
  // Configuration
  output amc_pkg::amc_cfg_t                 cfg_o,
  output logic [3:0]                        eff_rate_o
);

  localparam int          DIV_W   = $clog2(CONV_DIV + 1);
  localparam int unsigned TICK_NS = CONV_DIV * amc_pkg::CLK_NS;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);

  typedef enum {S_IDLE, S_DELAY, S_CONV} amc_state_t;

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [7:0]                  conversion_mode_control_q;
  logic [7:0]                  filter_and_bias_control_q;
  logic [7:0]                  gain_and_rate_control_q;
  logic                        pready_q;
  logic                        pslverr_q;
  logic [amc_pkg::DATA_W-1:0]  prdata_q;
  logic [amc_pkg::DATA_W-1:0]  rd_mux;
  logic [7:0]                  status_w;

  wire [amc_pkg::IDX_W-1:0] idx     = paddr_i[amc_pkg::ADDR_W-1:2];
  wire                      aligned = (paddr_i[1:0] == 2'b00);
  wire                      hit0    = aligned && idx == amc_pkg::CONVERSION_MODE_CONTROL_IDX;
  wire                      hit1    = aligned && idx == amc_pkg::FILTER_AND_BIAS_CONTROL_IDX;
  wire                      hit2    = aligned && idx == amc_pkg::GAIN_AND_RATE_CONTROL_IDX;
  wire                      hit_st  = aligned && idx == amc_pkg::STATUS_IDX;
  wire                      setup   = psel_i & ~penable_i;
  wire                      bad     = ~(hit0 | hit1 | hit2 | hit_st)
                                      | (pwrite_i & hit_st);
  wire                      wr_ok   = psel_i & penable_i & pready_q
                                      & pwrite_i & ~pslverr_q & pstrb_i[0];
  wire                      wr0     = wr_ok & hit0;
  wire                      wr1     = wr_ok & hit1;
  wire                      wr2     = wr_ok & hit2;

  // Reads return the stored byte, reserved codes included
  assign rd_mux = hit0   ? {24'h000000, conversion_mode_control_q}  :
                  hit1   ? {24'h000000, filter_and_bias_control_q}  :
                  hit2   ? {24'h000000, gain_and_rate_control_q}  :
                  hit_st ? {24'h000000, status_w} : '0;

  // Answer is prepared in setup, so access completes in one cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & bad;
      if (setup) begin
        prdata_q <= pwrite_i ? '0 : rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      conversion_mode_control_q <= amc_pkg::CONVERSION_MODE_CONTROL_RST;
      filter_and_bias_control_q <= amc_pkg::FILTER_AND_BIAS_CONTROL_RST;
      gain_and_rate_control_q <= amc_pkg::GAIN_AND_RATE_CONTROL_RST;
    end else begin
      if (wr0) begin
        conversion_mode_control_q <= pwdata_i[7:0];
      end
      if (wr1) begin
        filter_and_bias_control_q <= pwdata_i[7:0];
      end
      if (wr2) begin
        gain_and_rate_control_q <= pwdata_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Field decode
  wire [2:0] filt_w = filter_and_bias_control_q[amc_pkg::FILT_LSB +: 3];
  wire [3:0] rate_w = gain_and_rate_control_q[amc_pkg::RATE_LSB +: 4];
  wire [3:0] dly_w  = conversion_mode_control_q[amc_pkg::DELAY_LSB +: 4];
  wire       fir_w  = (filt_w == amc_pkg::FILT_FIR);
  wire       fir_ok = (rate_w <= amc_pkg::RATE_FIR3)
                      || (rate_w == amc_pkg::RATE_20);
  wire       clamp  = fir_w & ~fir_ok;

  assign cfg_o.reference_polarity_invert   = conversion_mode_control_q[amc_pkg::REFINV_BIT];
  assign cfg_o.single_or_continuous_select = conversion_mode_control_q[amc_pkg::RUN_BIT];
  assign cfg_o.input_chop_en      = conversion_mode_control_q[amc_pkg::CHOP_BIT];
  assign cfg_o.current_rotate_en  = conversion_mode_control_q[amc_pkg::ROT_BIT];
  assign cfg_o.delay_code         = dly_w;
  assign cfg_o.filter_sel         = filt_w;
  assign cfg_o.bias_converter_route = filter_and_bias_control_q[amc_pkg::ROUTE_BIT];
  assign cfg_o.bias_pull_direction  = filter_and_bias_control_q[amc_pkg::PULL_BIT];
  assign cfg_o.bias_strength_code   = filter_and_bias_control_q[amc_pkg::MAG_LSB +: 3];
  assign cfg_o.pga_bypass         = gain_and_rate_control_q[amc_pkg::BYP_BIT];
  assign cfg_o.gain_code          = gain_and_rate_control_q[amc_pkg::GAIN_LSB +: 3];
  assign cfg_o.output_rate_code   = rate_w;

  // Under FIR an unsupported rate falls back to 20 SPS
  logic [3:0] eff_rate_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      eff_rate_q <= amc_pkg::GAIN_AND_RATE_CONTROL_RST[3:0];
    end else begin
      eff_rate_q <= clamp ? amc_pkg::RATE_20 : rate_w;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Conversion clock enable
  logic [DIV_W-1:0] div_q;
  logic             tick_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == DIV_LAST);
      div_q  <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Start sequencer
  amc_state_t state_q;
  amc_state_t state_d;
  logic       go_q;
  logic       go_d;
  logic       tmr_done;
  logic       tmr_busy;

  wire single_w = conversion_mode_control_q[amc_pkg::RUN_BIT];
  wire start_ok = (state_q == S_IDLE) & conv_start_i & ~conv_stop_i;
  wire [amc_pkg::DLY_W-1:0] dly_ticks =
    amc_pkg::amc_dly_ticks(dly_w, TICK_NS);

  amc_delay_timer #(
    .W (amc_pkg::DLY_W)
  ) amc_delay_timer_i (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tick_i    (tick_q),
    .load_i    (start_ok),
    .abort_i   (conv_stop_i),
    .ticks_i   (dly_ticks),
    .done_o    (tmr_done),
    .busy_o    (tmr_busy)
  );

  always_comb begin
    state_d = state_q;
    go_d    = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (start_ok) begin
          state_d = S_DELAY;
        end
      end
      S_DELAY: begin
        if (conv_stop_i) begin
          state_d = S_IDLE;
        end else if (tmr_done) begin
          state_d = S_CONV;
          go_d    = 1'b1;
        end
      end
      S_CONV: begin
        if (conv_stop_i) begin
          state_d = S_IDLE;
        end else if (conv_done_i) begin
          state_d = single_w ? S_IDLE : S_CONV;
          go_d    = ~single_w;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      go_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      go_q    <= go_d;
    end
  end

  logic busy_q;
  logic dlyst_q;
  logic clamp_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q  <= 1'b0;
      dlyst_q <= 1'b0;
      clamp_q <= 1'b0;
    end else begin
      busy_q  <= (state_d != S_IDLE);
      dlyst_q <= tmr_busy;
      clamp_q <= clamp;
    end
  end

  assign status_w = {5'h00, clamp_q, dlyst_q, busy_q};

  assign pready_o    = pready_q;
  assign pslverr_o   = pslverr_q;
  assign prdata_o    = prdata_q;
  assign conv_go_o   = go_q;
  assign conv_busy_o = busy_q;
  assign eff_rate_o  = eff_rate_q;

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_conversion_mode_control_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr0 |=> cfg_o.reference_polarity_invert == $past(pwdata_i[7])
        && cfg_o.single_or_continuous_select == $past(pwdata_i[6])
        && {cfg_o.current_rotate_en, cfg_o.input_chop_en} == $past(pwdata_i[5:4]))
    else $error("first mode register write not applied");

  chk_filter_and_bias_control_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr1 |=> {cfg_o.filter_sel, cfg_o.bias_converter_route,
             cfg_o.bias_pull_direction, cfg_o.bias_strength_code}
            == $past(pwdata_i[7:0]))
    else $error("second mode register write not applied");

  chk_gain_and_rate_control_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr2 |=> {cfg_o.pga_bypass, cfg_o.gain_code, cfg_o.output_rate_code}
            == $past(pwdata_i[7:0]))
    else $error("third mode register write not applied");

  chk_read_back: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (setup && !pwrite_i && hit1) |=> pready_o && prdata_o[7:0] == $past(filter_and_bias_control_q))
    else $error("read data differ from stored register");

  chk_fir_rate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (fir_w && $stable(filter_and_bias_control_q) && $stable(gain_and_rate_control_q))
      |-> eff_rate_o <= amc_pkg::RATE_FIR3 || eff_rate_o == amc_pkg::RATE_20)
    else $error("unsupported rate passed under FIR filter");

  chk_single_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == S_CONV && single_w && conv_done_i && !conv_stop_i)
      |=> state_q == S_IDLE && !go_q)
    else $error("single conversion did not stop");

  chk_cont_again: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == S_CONV && !single_w && conv_done_i && !conv_stop_i) |=> go_q)
    else $error("continuous conversion did not restart");

  chk_zero_delay: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_ok && dly_w == 4'h0) ##1 (!conv_stop_i) [*2] |=> go_q)
    else $error("no-delay start late or missing");

  chk_delay_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_ok && dly_w != 4'h0 && dly_w <= amc_pkg::DLY_LAST) |=> !go_q [*8])
    else $error("programmed delay cut short");

  chk_unmapped: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (setup && !(hit0 || hit1 || hit2 || hit_st)) |=> pready_o && pslverr_o)
    else $error("unmapped access not refused");

endmodule
`default_nettype wire

// ### dv/amc_conv_model.sv
/*
  Behavioural converter core: answers each conversion start pulse
  with a one-cycle done pulse after a latency set by the bench.
  Assumes it shares clock and reset with the configuration block.
*/
`timescale 1ns/1ns
`default_nettype none
module amc_conv_model (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Conversion control
  input  wire logic       go_i,
  input  wire logic [7:0] lat_i,
  // Conversion result
  output logic            done_o
);
  logic [7:0] cnt_q;

  ////////////////////////////////////////////////////////////////////
  // Latency counter, restarted by every start pulse
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= !go_i && (cnt_q == 8'h01);
      if (go_i) begin
        cnt_q <= lat_i;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/amc_mode_regs_tb_top.sv
/*
  Self-checking bench for the mode configuration registers and the
  conversion start sequencer, driven over APB.
  Assumes CONV_DIV of 1, so one conversion tick per 10 ns cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module amc_mode_regs_tb_top;
  logic              clk_sys_i, rst_i, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]        paddr, lat;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        pstrb, eff_rate;
  logic              conv_start, conv_stop, conv_done, conv_go, conv_busy;
  amc_pkg::amc_cfg_t cfg;
  logic [7:0]        mir [3];
  logic [9:0]        tbl [19] = '{10'h080, 10'h040, 10'h010, 10'h020, 10'h030, 10'h00b,
    10'h100, 10'h120, 10'h140, 10'h160, 10'h110, 10'h108, 10'h106, 10'h107,
    10'h280, 10'h250, 10'h260, 10'h270, 10'h20f};
  int                dns [4] = '{0, 8700, 17000, 35000};
  int                bad_count, comparisons, n, t, gos;

  amc_mode_regs #(.CONV_DIV(1)) amc_mode_regs_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .conv_start_i(conv_start), .conv_stop_i(conv_stop), .conv_done_i(conv_done),
    .conv_go_o(conv_go), .conv_busy_o(conv_busy), .cfg_o(cfg), .eff_rate_o(eff_rate));

  amc_conv_model amc_conv_model_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .go_i(conv_go), .lat_i(lat), .done_o(conv_done));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////
  // Checking and closing
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task summarize();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #400000;
    bad_count++;
    $display("wrong value watchdog expected finish seen timeout");
    summarize();
  end

  ////////////////////////////////////////////////////////////////////
  // APB master: request held until pready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= st;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, k < 100});
  endtask

  task wreg(input int i, input logic [7:0] d);
    apb(1'b1, 8'(8'h0c + 4 * i), {24'h0, d}, 4'hf);
    mir[i] = d;
    chk("write error", 32'h0, {31'h0, err});
  endtask

  task rreg(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk("read data", exp, rd);
  endtask

  function automatic amc_pkg::amc_cfg_t ecfg();
    amc_pkg::amc_cfg_t c;
    c.reference_polarity_invert   = mir[0][7];
    c.single_or_continuous_select = mir[0][6];
    c.input_chop_en               = mir[0][4];
    c.current_rotate_en           = mir[0][5];
    c.delay_code                  = mir[0][3:0];
    c.filter_sel                  = mir[1][7:5];
    c.bias_converter_route        = mir[1][4];
    c.bias_pull_direction         = mir[1][3];
    c.bias_strength_code          = mir[1][2:0];
    c.pga_bypass                  = mir[2][7];
    c.gain_code                   = mir[2][6:4];
    c.output_rate_code            = mir[2][3:0];
    return c;
  endfunction

  function automatic logic [3:0] erate();
    if (mir[1][7:5] == 3'h4 && !(mir[2][3:0] inside {4'h0, 4'h1, 4'h2, 4'h4}))
      return 4'h4;
    return mir[2][3:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Sequencer helpers: start pulse to go, and counting go pulses over a fixed wait
  task startm(output int cyc);
    @(posedge clk_sys_i);
    conv_start <= 1'b1;
    cyc = 0;
    do begin
      @(posedge clk_sys_i);
      conv_start <= 1'b0;
      cyc++;
      @(negedge clk_sys_i);
    end while (conv_go !== 1'b1 && cyc < 5000);
  endtask

  task idle_check(input int cyc);
    gos = 0;
    repeat (cyc) begin
      @(negedge clk_sys_i);
      gos += int'(conv_go === 1'b1);
    end
    chk("busy", 32'h0, {31'h0, conv_busy});
  endtask

  ////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {conv_start, conv_stop, bad_count, comparisons} = '0;
    lat   = 8'h04;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    mir = '{8'h00, 8'h80, 8'h04};
    for (int i = 0; i < 3; i++) rreg(8'(8'h0c + 4 * i), {24'h0, mir[i]});
    chk("cfg", 32'(ecfg()), 32'(cfg));
    chk("eff rate", 32'h4, {28'h0, eff_rate});
    foreach (tbl[i]) begin
      wreg(int'(tbl[i][9:8]), tbl[i][7:0]);
      rreg(8'(8'h0c + 4 * tbl[i][9:8]), {24'h0, tbl[i][7:0]});
      chk("cfg", 32'(ecfg()), 32'(cfg));
    end
    foreach (mir[i]) wreg(i, 8'h00);
    for (int f = 0; f < 2; f++) begin
      wreg(1, f ? 8'h60 : 8'h80);
      for (int c = 0; c < 16; c++) begin
        wreg(2, 8'(c));
        repeat (2) @(posedge clk_sys_i);
        chk("eff rate", {28'h0, erate()}, {28'h0, eff_rate});
      end
    end
    apb(1'b1, 8'h18, 32'hff, 4'hf);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, 8'hfc, 32'hff, 4'hf);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, 8'h0d, 32'hff, 4'hf);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, 8'h14, 32'hff, 4'h0);
    rreg(8'h00, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    for (int i = 0; i < 3; i++) rreg(8'(8'h0c + 4 * i), {24'h0, mir[i]});
    wreg(0, 8'h40);
    startm(n);
    chk("go delay", 32'd3, 32'(n));
    idle_check(30);
    chk("go count", 32'h0, 32'(gos));
    for (int d = 1; d < 4; d++) begin
      wreg(0, 8'(8'h40 + d));
      t = (dns[d] + 9) / 10;
      startm(n);
      chk("go delay in range", 32'h1, {31'h0, n >= t + 3 && n <= t + 4});
      idle_check(30);
    end
    lat = 8'd20;
    wreg(0, 8'h02);
    startm(n);
    chk("go delay in range", 32'h1, {31'h0, n >= 1703 && n <= 1704});
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (conv_done !== 1'b1 && n < 100);
    @(negedge clk_sys_i);
    chk("restart go", 32'h1, {31'h0, conv_go});
    rreg(8'hfc, 32'h1);
    @(posedge clk_sys_i);
    conv_stop <= 1'b1;
    @(posedge clk_sys_i);
    conv_stop <= 1'b0;
    idle_check(40);
    chk("go count", 32'h0, 32'(gos));
    summarize();
  end
endmodule
`default_nettype wire
